// File: bei_regs.vh
`ifndef BEI_REGS_VH
`define BEI_REGS_VH

// ==========================================================
// timing source selection
`define BEI_SRC_INTERNAL   2'h0
`define BEI_SRC_EXT_TRIG   2'h1
`define BEI_SRC_EXT_GATE   2'h2

// ==========================================================
// insertion method and route mode
`define BEI_METH_REPEAT    1'h0
`define BEI_METH_SINGLE    1'h1
`define BEI_ROUTE_FIXED    1'h0
`define BEI_ROUTE_SCAN     1'h1

// ==========================================================
// mixed pattern segment codes
`define BEI_SEG_DATA       1'h0
`define BEI_SEG_PRBS       1'h1

// ==========================================================
// rate limits
`define BEI_MANT_MIN       4'h1
`define BEI_MANT_MAX       4'h9
`define BEI_MANT_MAX_E3    4'h5
`define BEI_EXP_MIN        4'h3
`define BEI_EXP_MAX        4'hC

// ==========================================================
// route limits, numbers are 1-based
`define BEI_ROUTE_MIN      6'h01
`define BEI_ROUTE_MAX      6'h20

// ==========================================================
// reset values
`define BEI_RST_ACC        41'h0
`define BEI_RST_SCAN       5'h00
`define BEI_RST_PEND       3'h0
`define BEI_RST_DATA       32'h0

`endif

// File: bei_core.v
`timescale 1ns/10ps
`default_nettype none
`include "bei_regs.vh"

// Overview of operation
// - master enable gates every insertion path
// - source choice only with aux injection role
// - internal source uses own rate generator
// - external trigger inserts on aux edge
// - gated source suppresses while aux low
// - repeat/single only for internal or gated
// - repeat inserts continuously at set rate
// - single command inserts one per channel
// - stream is 32 routes, route places error
// - scan mode rotates route per error
// - fixed mode uses configured route 1..32
// - route kept when off, ignored in scan
// - rate mantissa 1..9, exponent 3..12
// - exponent 3 limits mantissa to 5
// - rate kept when off, ignored otherwise
// - mixed pattern confines insertion to region
module bei_core #(
  parameter ROUTES = 32,
  parameter BLK_W  = 9
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              rst_n,
  // control
  input  wire              err_enable,
  input  wire              aux_role_inj,
  input  wire [1:0]        src_sel,
  input  wire              method_sel,
  input  wire              single_cmd,
  input  wire [2:0]        comb_chans,
  input  wire              route_mode,
  input  wire [5:0]        route_num,
  input  wire [3:0]        rate_mant,
  input  wire [3:0]        rate_exp,
  input  wire              trig_falling,
  // mixed pattern region
  input  wire              mixed_en,
  input  wire              seg_sel,
  input  wire [BLK_W-1:0]  blk_sel,
  // auxiliary pin
  input  wire              aux_in,
  // pattern stream in
  input  wire              in_valid,
  input  wire [ROUTES-1:0] in_data,
  input  wire              in_seg,
  input  wire [BLK_W-1:0]  in_blk,
  // pattern stream out
  output reg               out_valid,
  output reg  [ROUTES-1:0] out_data,
  output reg               err_flag,
  output reg  [4:0]        err_route,
  output wire              single_busy
);

  // ==========================================================
  // power-of-ten threshold lookup
  function [40:0] pow10;
    input [3:0] n;
    begin
      case (n)
        4'h3:    pow10 = 41'h00000003E8;
        4'h4:    pow10 = 41'h0000002710;
        4'h5:    pow10 = 41'h00000186A0;
        4'h6:    pow10 = 41'h00000F4240;
        4'h7:    pow10 = 41'h0000989680;
        4'h8:    pow10 = 41'h0005F5E100;
        4'h9:    pow10 = 41'h003B9ACA00;
        4'hA:    pow10 = 41'h02540BE400;
        4'hB:    pow10 = 41'h174876E800;
        default: pow10 = 41'hE8D4A51000;
      endcase
    end
  endfunction

  // ==========================================================
  // auxiliary input synchroniser
  reg aux_s1_r;
  reg aux_s2_r;
  reg aux_s3_r;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_s1_r <= 1'b0;
      aux_s2_r <= 1'b0;
      aux_s3_r <= 1'b0;
    end
    else
    begin
      aux_s1_r <= aux_in;
      aux_s2_r <= aux_s1_r;
      aux_s3_r <= aux_s2_r;
    end
  end

  wire aux_lvl  = aux_s2_r;
  wire aux_rise = aux_s2_r & ~aux_s3_r;
  wire aux_fall = ~aux_s2_r & aux_s3_r;
  wire aux_edge = trig_falling ? aux_fall : aux_rise;

  // ==========================================================
  // effective mode decode
  // without the injection role the source setting is ignored
  wire [1:0] src_eff = aux_role_inj ? src_sel : `BEI_SRC_INTERNAL;
  wire is_trig = (src_eff == `BEI_SRC_EXT_TRIG);
  wire is_gate = (src_eff == `BEI_SRC_EXT_GATE);
  // method only matters for internal or gated timing
  wire is_single = ~is_trig & (method_sel == `BEI_METH_SINGLE);
  wire is_repeat = ~is_trig & (method_sel == `BEI_METH_REPEAT);
  wire gate_ok   = ~is_gate | aux_lvl;

  // ==========================================================
  // rate clamping
  reg [3:0] exp_eff;
  reg [3:0] mant_eff;

  always @*
  begin
    exp_eff = rate_exp;
    if (rate_exp < `BEI_EXP_MIN)
      exp_eff = `BEI_EXP_MIN;
    else if (rate_exp > `BEI_EXP_MAX)
      exp_eff = `BEI_EXP_MAX;
    mant_eff = rate_mant;
    if (rate_mant < `BEI_MANT_MIN)
      mant_eff = `BEI_MANT_MIN;
    else if (rate_mant > `BEI_MANT_MAX)
      mant_eff = `BEI_MANT_MAX;
    if ((exp_eff == `BEI_EXP_MIN) && (mant_eff > `BEI_MANT_MAX_E3))
      mant_eff = `BEI_MANT_MAX_E3;
  end

  // ==========================================================
  // internal rate generator
  // each word carries ROUTES bits, so the accumulator gains
  // ROUTES times the mantissa per word; at the top rate this
  // still gives below one error per word
  reg  [40:0] acc_r;
  reg  [40:0] acc_nxt;
  reg         gen_fire;
  // route count widened to the accumulator width
  localparam [40:0] ROUTES_W = ROUTES;
  wire [40:0] thr  = pow10(exp_eff);
  wire [40:0] incr = {37'h0, mant_eff} * ROUTES_W;
  wire [40:0] acc_sum = acc_r + incr;
  wire        gen_run = err_enable & is_repeat;

  always @*
  begin
    acc_nxt  = acc_r;
    gen_fire = 1'b0;
    if (!gen_run)
      acc_nxt = `BEI_RST_ACC;
    else if (in_valid)
    begin
      if (acc_sum >= thr)
      begin
        gen_fire = 1'b1;
        acc_nxt  = acc_sum - thr;
      end
      else
        acc_nxt = acc_sum;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_r <= `BEI_RST_ACC;
    else
      acc_r <= acc_nxt;
  end

  // ==========================================================
  // mixed pattern region qualifier
  wire in_region = ~mixed_en | ((in_seg == seg_sel) && (in_blk == blk_sel));
  wire slot_ok   = in_valid & in_region & gate_ok;

  // ==========================================================
  // pending single and trigger requests
  // single waits for an eligible word instead of being dropped,
  // so a command issued while gated low still yields its error
  reg  [2:0] pend_r;
  reg  [2:0] pend_nxt;
  reg        trig_pend_r;
  reg        trig_pend_nxt;
  reg        fire;
  wire [2:0] chans = (comb_chans == 3'h0) ? 3'h1 : comb_chans;

  always @*
  begin
    pend_nxt      = pend_r;
    trig_pend_nxt = trig_pend_r;
    fire          = 1'b0;
    if (!err_enable)
    begin
      pend_nxt      = `BEI_RST_PEND;
      trig_pend_nxt = 1'b0;
    end
    else if (is_trig)
    begin
      pend_nxt = `BEI_RST_PEND;
      if (trig_pend_r && slot_ok)
      begin
        fire          = 1'b1;
        trig_pend_nxt = 1'b0;
      end
      // an edge in the consuming cycle is kept, not lost
      if (aux_edge)
        trig_pend_nxt = 1'b1;
    end
    else if (is_single)
    begin
      trig_pend_nxt = 1'b0;
      if ((pend_r != 3'h0) && slot_ok)
      begin
        fire     = 1'b1;
        pend_nxt = pend_r - 3'h1;
      end
      // a new command while busy is ignored
      if (single_cmd && (pend_r == 3'h0))
        pend_nxt = chans;
    end
    else
    begin
      pend_nxt      = `BEI_RST_PEND;
      trig_pend_nxt = 1'b0;
      fire          = gen_fire & in_region & gate_ok;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_r      <= `BEI_RST_PEND;
      trig_pend_r <= 1'b0;
    end
    else
    begin
      pend_r      <= pend_nxt;
      trig_pend_r <= trig_pend_nxt;
    end
  end

  assign single_busy = (pend_r != 3'h0);

  // ==========================================================
  // route selection
  reg  [4:0] scan_r;
  reg  [4:0] fix_idx;
  wire [4:0] route_idx = (route_mode == `BEI_ROUTE_SCAN) ? scan_r : fix_idx;

  always @*
  begin
    // out-of-range numbers clamp into 1..32, stored value untouched
    if (route_num < `BEI_ROUTE_MIN)
      fix_idx = 5'h00;
    else if (route_num > `BEI_ROUTE_MAX)
      fix_idx = 5'h1F;
    else
      fix_idx = route_num[4:0] - 5'h01;
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      scan_r <= `BEI_RST_SCAN;
    else if (fire && (route_mode == `BEI_ROUTE_SCAN))
      scan_r <= scan_r + 5'h01;
  end

  // ==========================================================
  // output word with single-bit inversion
  wire [ROUTES-1:0] flip_mask = {{(ROUTES-1){1'b0}}, 1'b1} << route_idx;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_data  <= `BEI_RST_DATA;
      err_flag  <= 1'b0;
      err_route <= 5'h00;
    end
    else
    begin
      out_valid <= in_valid;
      err_flag  <= fire;
      if (in_valid)
        out_data <= fire ? (in_data ^ flip_mask) : in_data;
      if (fire)
        err_route <= route_idx;
    end
  end

endmodule // bei_core

`default_nettype wire

// File: bei_chk_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "bei_regs.vh"
// ======================================
// insertion checks at the core ports
module bei_chk #(
  parameter ROUTES = 32,
  parameter BLK_W  = 9
) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // control
  input wire logic              err_enable,
  input wire logic              aux_role_inj,
  input wire logic [1:0]        src_sel,
  input wire logic              route_mode,
  input wire logic [5:0]        route_num,
  input wire logic              mixed_en,
  input wire logic              seg_sel,
  input wire logic [BLK_W-1:0]  blk_sel,
  input wire logic              aux_in,
  // stream
  input wire logic              in_valid,
  input wire logic [ROUTES-1:0] in_data,
  input wire logic              in_seg,
  input wire logic [BLK_W-1:0]  in_blk,
  input wire logic              out_valid,
  input wire logic [ROUTES-1:0] out_data,
  input wire logic              err_flag,
  input wire logic [4:0]        err_route,
  input wire logic              single_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] scan_r;
  // only scan errors move the pointer
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) scan_r <= 5'h00;
    else if (err_flag && route_mode) scan_r <= scan_r + 5'h01;
  sequence s_gate_low;
    (aux_role_inj && src_sel == `BEI_SRC_EXT_GATE && !aux_in) [*5];
  endsequence
  // long enough for a late edge to drain through the synchroniser
  sequence s_trig_quiet;
    (aux_role_inj && src_sel == `BEI_SRC_EXT_TRIG && !mixed_en && in_valid && $stable(aux_in)) [*8];
  endsequence
  property p_off; !err_enable |=> !err_flag; endproperty
  property p_clean; in_valid ##1 !err_flag |-> out_data == $past(in_data); endproperty
  property p_flip; err_flag |-> (out_data ^ $past(in_data)) == (ROUTES'(1) << err_route); endproperty
  property p_fixed;
    err_flag && !$past(route_mode) && $past(route_num) inside {[6'h01:6'h20]}
      |-> err_route == 5'($past(route_num) - 6'h01);
  endproperty
  property p_scan; err_flag && route_mode |-> err_route == scan_r; endproperty
  property p_gate; s_gate_low |-> !err_flag; endproperty
  property p_quiet; s_trig_quiet |-> !err_flag; endproperty
  property p_single; $fell(single_busy) && $past(err_enable) |-> err_flag; endproperty
  property p_valid; out_valid == $past(in_valid); endproperty
  property p_region;
    err_flag && $past(mixed_en) |-> $past(in_seg) == $past(seg_sel) && $past(in_blk) == $past(blk_sel);
  endproperty
  a_off: assert property (p_off) else $error("error while disabled");
  a_clean: assert property (p_clean) else $error("word altered");
  a_flip: assert property (p_flip) else $error("flip not on route");
  a_fixed: assert property (p_fixed) else $error("fixed route wrong");
  a_scan: assert property (p_scan) else $error("scan order wrong");
  a_gate: assert property (p_gate) else $error("error while gated");
  a_quiet: assert property (p_quiet) else $error("error without edge");
  a_single: assert property (p_single) else $error("single lost");
  a_valid: assert property (p_valid) else $error("word valid misaligned");
  a_region: assert property (p_region) else $error("error outside region");
endmodule // bei_chk
bind bei_core bei_chk #(.ROUTES(ROUTES), .BLK_W(BLK_W)) u_chk (.core_clk, .rst_n, .err_enable, .aux_role_inj,
  .src_sel, .route_mode, .route_num, .mixed_en, .seg_sel, .blk_sel, .aux_in, .in_valid, .in_data, .in_seg,
  .in_blk, .out_valid, .out_data, .err_flag, .err_route, .single_busy);
`default_nettype wire

// File: bei_src.sv
`timescale 1ns/10ps
`default_nettype none
// ======================================
// serializer side word source
module bei_src (
  // clock and control
  input  wire logic       core_clk,
  input  wire logic       run,
  // stream
  output var  logic       in_valid,
  output var  logic [31:0] in_data,
  output var  logic       in_seg,
  output var  logic [8:0] in_blk
);
  initial {in_valid, in_data, in_seg, in_blk} = {1'b0, 32'h00000001, 1'b0, 9'h000};
  // one 32 route word per cycle; idle words flip so stale data never matches
  always @(posedge core_clk)
  begin
    in_valid <= #2 run;
    in_data  <= #2 run ? in_data * 32'h0019660D + 32'h3C6EF35F : ~in_data;
    // eight blocks per segment, segment toggles on wrap, so a region recurs every 16 words
    if (run)
    begin
      in_blk <= #2 (in_blk == 9'h007) ? 9'h000 : in_blk + 9'h001;
      in_seg <= #2 (in_blk == 9'h007) ? ~in_seg : in_seg;
    end
  end
endmodule // bei_src
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bei_regs.vh"
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, err_enable = 1'b0, aux_role_inj = 1'b0, method_sel = 1'b0, run = 1'b0;
  logic single_cmd = 1'b0, route_mode = 1'b1, trig_falling = 1'b0, mixed_en = 1'b0, seg_sel = 1'b0, aux_in = 1'b0;
  logic [1:0] src_sel = `BEI_SRC_INTERNAL;
  logic [2:0] comb_chans = 3'h3;
  logic [5:0] route_num = 6'h07;
  logic [3:0] rate_mant = 4'h5, rate_exp = 4'h3;
  logic [8:0] blk_sel = 9'h000;
  wire        in_valid, in_seg, out_valid, err_flag, single_busy;
  wire [31:0] in_data, out_data;
  wire [8:0]  in_blk;
  wire [4:0]  err_route;
  int n_mismatch = 0, num_checks = 0, n_err = 0;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (err_flag !== 1'b0) n_err <= n_err + 1;
  bei_core dut (.core_clk, .rst_n, .err_enable, .aux_role_inj, .src_sel, .method_sel, .single_cmd, .comb_chans,
    .route_mode, .route_num, .rate_mant, .rate_exp, .trig_falling, .mixed_en, .seg_sel, .blk_sel, .aux_in,
    .in_valid, .in_data, .in_seg, .in_blk, .out_valid, .out_data, .err_flag, .err_route, .single_busy);
  bei_src u_src (.core_clk, .run, .in_valid, .in_data, .in_seg, .in_blk);
  // ======================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic int nexp(input int m, input int e);
    return 700 * 32 * m / 10 ** e;
  endfunction
  // n words with insertion on or off; single command is raised with run, one cycle before the first word
  task automatic burst(input int n, input logic en, input int exp);
    n_err = 0;
    err_enable = en;
    cyc(1);
    single_cmd = method_sel;
    run = 1'b1;
    cyc(1);
    single_cmd = 1'b0;
    cyc(n - 1);
    run = 1'b0;
    cyc(3);
    err_enable = 1'b0;
    chk(n_err, exp);
  endtask
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ======================================
  // scenarios
  initial
  begin
    cyc(2);
    chk(out_data, 32'h0);
    chk({25'h0, out_valid, err_flag, err_route}, 32'h0);
    cyc(1);
    rst_n = 1'b1;
    cyc(4);
    burst(700, 1'b1, nexp(5, 3));
    chk(err_route, (nexp(5, 3) - 1) % 32);
    route_mode = 1'b0;
    burst(700, 1'b1, nexp(5, 3));
    chk(err_route, 5'h06);
    burst(700, 1'b0, 0);
    // reset between bursts, with run low, clears outputs and the scan pointer
    rst_n = 1'b0;
    cyc(1);
    chk(out_data, 32'h0);
    chk({25'h0, out_valid, err_flag, err_route}, 32'h0);
    rst_n = 1'b1;
    cyc(3);
    rate_mant = 4'h9;
    burst(700, 1'b1, nexp(5, 3));
    rate_exp = 4'h4;
    burst(700, 1'b1, nexp(9, 4));
    src_sel = `BEI_SRC_EXT_TRIG;
    burst(700, 1'b1, nexp(9, 4));
    aux_role_inj = 1'b1;
    src_sel = `BEI_SRC_EXT_GATE;
    burst(700, 1'b1, 0);
    aux_in = 1'b1;
    burst(700, 1'b1, nexp(9, 4));
    src_sel = `BEI_SRC_INTERNAL;
    method_sel = 1'b1;
    burst(700, 1'b1, 3);
    chk(single_busy, 1'b0);
    mixed_en = 1'b1;
    seg_sel = 1'b1;
    blk_sel = 9'h005;
    burst(100, 1'b1, 3);
    mixed_en = 1'b0;
    comb_chans = 3'h0;
    burst(700, 1'b1, 1);
    aux_in = 1'b0;
    src_sel = `BEI_SRC_EXT_TRIG;
    burst(700, 1'b1, 0);
    for (int i = 0; i < 3; i++)
    begin
      trig_falling = i[0];
      // aux pulses stand for the far side's trigger, one edge of each kind per pulse
      fork
        burst(60, i < 2, i < 2 ? 4 : 0);
        begin
          cyc(3);
          repeat (4) begin aux_in = 1'b1; cyc(5); aux_in = 1'b0; cyc(5); end
        end
      join
    end
    test_done;
  end
  initial
  begin
    cyc(20000);
    n_mismatch++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
